// *** shared/rpvm_pkg.sv ***
// Contract
// - Report the length of the last line seen in the latest frame.
// - With change interrupt enabled, hold the reported length until read.
// - Reading the high byte latches the low byte for a coherent pair.
// - Capture a new frequency only when it moves beyond the hysteresis.
// - Declare the clock stable after it stays in band for the selected time.
// - Flag a missing link clock when frequency is below the low limit.
// - Two free scratch bytes, reset to 0x00 and 0x01.
// - Sticky length-mismatch flag at bit 3, cleared on read.
// - Sticky payload checksum flag at bit 2, cleared on read.
// - Sticky multi-bit header flag at bit 1, header left uncorrected.
// - Correct single-bit header errors, sticky flag at bit 0.
// - Port-select register at 0x4C steers per-port register accesses.
package rpvm_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int NUM_PORTS     = 4;
  localparam int LEN_W         = 16;
  localparam int FREQ_W        = 8;
  localparam int HDR_W         = 24;
  localparam int POS_W         = 5;
  localparam int FLAG_W        = 4;

  localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;
  localparam logic [7:0] ADDR_LEN_HI   = 8'h75;
  localparam logic [7:0] ADDR_LEN_LO   = 8'h76;
  localparam logic [7:0] ADDR_FREQ_CTL = 8'h77;
  localparam logic [7:0] ADDR_MBOX_A   = 8'h78;
  localparam logic [7:0] ADDR_MBOX_B   = 8'h79;
  localparam logic [7:0] ADDR_FLAGS    = 8'h7A;

  localparam int HYST_LSB   = 6;
  localparam int STABLE_LSB = 4;
  localparam int LOW_LSB    = 0;
  localparam int FLAG_LEN   = 3;
  localparam int FLAG_CKSUM = 2;
  localparam int FLAG_ECC2  = 1;
  localparam int FLAG_ECC1  = 0;

  localparam logic [7:0] FREQ_CTL_RST = 8'hC5;
  localparam logic [7:0] MBOX_A_RST   = 8'h00;
  localparam logic [7:0] MBOX_B_RST   = 8'h01;
  localparam logic [7:0] PORT_SEL_RST = 8'h00;
  localparam logic [15:0] LEN_RST     = 16'h0000;

  localparam int STABLE_T0_NS = 40000;
  localparam int STABLE_T1_NS = 80000;
  localparam int STABLE_T2_NS = 320000;
  localparam int STABLE_T3_NS = 1280000;

  // A least time rounds up to whole cycles.
  function automatic int to_cycles(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int STABLE_CYC0 = to_cycles(STABLE_T0_NS);
  localparam int STABLE_CYC1 = to_cycles(STABLE_T1_NS);
  localparam int STABLE_CYC2 = to_cycles(STABLE_T2_NS);
  localparam int STABLE_CYC3 = to_cycles(STABLE_T3_NS);

  function automatic logic [FREQ_W-1:0] freq_dist(
    input logic [FREQ_W-1:0] a,
    input logic [FREQ_W-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  typedef enum logic [2:0] {
    LL_RUN     = 3'b001,
    LL_FROZEN  = 3'b010,
    LL_HI_READ = 3'b100
  } rpvm_ll_state_t;

endpackage

// *** hw/rpvm_line_len.sv ***
`timescale 1ns/1ps
module rpvm_line_len (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // Video line events
  input  wire logic                       line_end,
  input  wire logic [rpvm_pkg::LEN_W-1:0] line_len,
  input  wire logic                       frame_end,
  input  wire logic                       freeze_en,
  // Register reads
  input  wire logic                       rd_hi,
  input  wire logic                       rd_lo,
  output logic      [rpvm_pkg::LEN_W-1:0] len_report,
  output logic      [7:0]                 lo_read
);
  import rpvm_pkg::*;

  logic [LEN_W-1:0] cur_q, cur_d, rep_q, rep_d;
  logic [7:0]       latch_q, latch_d;
  logic             pend_q, pend_d;
  rpvm_ll_state_t   st_q, st_d;

  always_comb begin
    cur_d   = line_end ? line_len : cur_q;
    rep_d   = rep_q;
    st_d    = st_q;
    latch_d = latch_q;
    pend_d  = pend_q;
    if (rd_hi) begin
      latch_d = rep_q[7:0];
      pend_d  = 1'b1;
    end else if (rd_lo) begin
      pend_d = 1'b0;
    end
    unique case (st_q)
      LL_RUN: if (frame_end) begin
        rep_d = cur_d;
        if (freeze_en) st_d = LL_FROZEN;
      end
      LL_FROZEN: if (!freeze_en) st_d = LL_RUN;
        else if (rd_hi) st_d = LL_HI_READ;
      LL_HI_READ: if (!freeze_en || rd_lo) st_d = LL_RUN;
      default: st_d = LL_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_q   <= LEN_RST;
      rep_q   <= LEN_RST;
      latch_q <= 8'h00;
      pend_q  <= 1'b0;
      st_q    <= LL_RUN;
    end else begin
      cur_q   <= cur_d;
      rep_q   <= rep_d;
      latch_q <= latch_d;
      pend_q  <= pend_d;
      st_q    <= st_d;
    end
  end

  assign len_report = rep_q;
  // A lone low read with no pending high read sees the live value.
  assign lo_read    = pend_q ? latch_q : rep_q[7:0];

  a_final_line_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == LL_RUN && frame_end && line_end |=> rep_q == $past(line_len))
    else $error("length is not the frame's last line");
  a_frozen_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q != LL_RUN |=> rep_q == $past(rep_q))
    else $error("frozen line length changed");
  a_lo_coherent: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd_hi |=> lo_read == $past(rep_q[7:0]))
    else $error("low byte not coherent with high byte");
  a_freeze_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_q == LL_HI_READ && rd_lo |=> st_q == LL_RUN)
    else $error("freeze not released after low read");

endmodule // rpvm_line_len

// *** hw/rpvm_freq_det.sv ***
`timescale 1ns/1ps
module rpvm_freq_det #(
  parameter int CYC0  = rpvm_pkg::STABLE_CYC0,
  parameter int CYC1  = rpvm_pkg::STABLE_CYC1,
  parameter int CYC2  = rpvm_pkg::STABLE_CYC2,
  parameter int CYC3  = rpvm_pkg::STABLE_CYC3,
  parameter int CNT_W = 17
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Measurement and control fields
  input  wire logic                        meas_valid,
  input  wire logic [rpvm_pkg::FREQ_W-1:0] freq_meas,
  input  wire logic [1:0]                  hyst,
  input  wire logic [1:0]                  stable_sel,
  input  wire logic [3:0]                  low_limit,
  // Status
  output logic      [rpvm_pkg::FREQ_W-1:0] freq_held,
  output logic                             freq_stable,
  output logic                             clk_missing
);
  import rpvm_pkg::*;

  if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 ||
      CYC0 >= 2**CNT_W || CYC1 >= 2**CNT_W ||
      CYC3 >= 2**CNT_W || CYC2 >= 2**CNT_W) begin : g_bad
    $error("stable counts do not fit the counter");
  end

  logic [FREQ_W-1:0] freq_q, freq_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d, limit;
  logic              stable_q, stable_d, miss_q, miss_d, capture;

  always_comb begin
    unique case (stable_sel)
      2'h0: limit = CNT_W'(CYC0);
      2'h1: limit = CNT_W'(CYC1);
      2'h2: limit = CNT_W'(CYC2);
      2'h3: limit = CNT_W'(CYC3);
    endcase
    capture = meas_valid &&
              freq_dist(freq_meas, freq_q) > {6'h00, hyst};
    freq_d  = capture ? freq_meas : freq_q;
    cnt_d    = capture ? '0 : (cnt_q >= limit ? cnt_q : cnt_q + 1'b1);
    stable_d = cnt_d >= limit;
    miss_d   = freq_d < {4'h0, low_limit};
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      freq_q   <= '0;
      cnt_q    <= '0;
      stable_q <= 1'b0;
      miss_q   <= 1'b1;
    end else begin
      freq_q   <= freq_d;
      cnt_q    <= cnt_d;
      stable_q <= stable_d;
      miss_q   <= miss_d;
    end
  end

  assign freq_held   = freq_q;
  assign freq_stable = stable_q;
  assign clk_missing = miss_q;

  a_hyst_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
    meas_valid && freq_dist(freq_meas, freq_q) <= {6'h00, hyst}
    |=> freq_q == $past(freq_q))
    else $error("frequency moved inside hysteresis band");
  a_stable_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
    capture |=> !stable_q ##0 (!stable_q || cnt_q >= limit))
    else $error("stable declared before its time");
  a_low_limit_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> miss_q == (freq_q < {4'h0, $past(low_limit)}))
    else $error("missing clock flag disagrees with limit");

endmodule // rpvm_freq_det

// *** hw/rpvm_top.sv ***
`timescale 1ns/1ps
module rpvm_top #(
  parameter int NUM_PORTS   = rpvm_pkg::NUM_PORTS,
  parameter int STABLE_CYC2 = rpvm_pkg::STABLE_CYC2,
  parameter int STABLE_CYC3 = rpvm_pkg::STABLE_CYC3
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,

  // Register access
  input  wire logic [7:0]                  reg_addr,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,

  // Video line measurement
  input  wire logic [NUM_PORTS-1:0]        line_end,
  input  wire logic [NUM_PORTS-1:0][rpvm_pkg::LEN_W-1:0] line_len,
  input  wire logic [NUM_PORTS-1:0]        frame_end,
  input  wire logic [NUM_PORTS-1:0]        line_length_change_irq_enable,

  // Link clock frequency
  input  wire logic [NUM_PORTS-1:0]        freq_valid,
  input  wire logic [NUM_PORTS-1:0][rpvm_pkg::FREQ_W-1:0] freq_meas,
  output logic      [NUM_PORTS-1:0][rpvm_pkg::FREQ_W-1:0] freq_held,
  output logic      [NUM_PORTS-1:0]        freq_stable,
  output logic      [NUM_PORTS-1:0]        link_clock_missing,

  // Packet error events
  input  wire logic [NUM_PORTS-1:0]        pkt_len_mismatch,
  input  wire logic [NUM_PORTS-1:0]        pkt_cksum_bad,
  input  wire logic [NUM_PORTS-1:0]        hdr_ecc_multi,
  input  wire logic [NUM_PORTS-1:0]        hdr_ecc_single,

  // Packet header correction
  input  wire logic [NUM_PORTS-1:0]        hdr_valid,
  input  wire logic [NUM_PORTS-1:0][rpvm_pkg::HDR_W-1:0] hdr_in,
  input  wire logic [NUM_PORTS-1:0][rpvm_pkg::POS_W-1:0] hdr_err_pos,
  output logic      [NUM_PORTS-1:0]        hdr_out_valid,
  output logic      [NUM_PORTS-1:0][rpvm_pkg::HDR_W-1:0] hdr_out
);
  import rpvm_pkg::*;

  localparam int PSEL_W = $clog2(NUM_PORTS);

  if (NUM_PORTS < 2 || NUM_PORTS > 8) begin : g_bad_ports
    $error("NUM_PORTS must lie between 2 and 8");
  end

  // Register file state.
  logic [PSEL_W-1:0]              sel_q, sel_d;
  logic [NUM_PORTS-1:0][7:0]      freq_ctl_q, freq_ctl_d;
  logic [NUM_PORTS-1:0][7:0]      mbox_a_q, mbox_a_d;
  logic [NUM_PORTS-1:0][7:0]      mbox_b_q, mbox_b_d;
  logic [NUM_PORTS-1:0][FLAG_W-1:0] flags_q, flags_d;
  logic [7:0]                     rdata_q, rdata_d;
  logic                           rvalid_q, rvalid_d;

  // Header path state.
  logic [NUM_PORTS-1:0][HDR_W-1:0] hdr_q, hdr_d;
  logic [NUM_PORTS-1:0]            hdr_v_q, hdr_v_d;

  // Per-port read strobes and submodule results.
  logic [NUM_PORTS-1:0]            rd_hi, rd_lo, rd_flags;
  logic [NUM_PORTS-1:0][LEN_W-1:0] len_rep;
  logic [NUM_PORTS-1:0][7:0]       len_lo;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd_hi[p]    = reg_rd && reg_addr == ADDR_LEN_HI &&
                    sel_q == PSEL_W'(p);
      rd_lo[p]    = reg_rd && reg_addr == ADDR_LEN_LO &&
                    sel_q == PSEL_W'(p);
      rd_flags[p] = reg_rd && reg_addr == ADDR_FLAGS &&
                    sel_q == PSEL_W'(p);
    end
  end

  // Register writes.
  always_comb begin
    sel_d      = sel_q;
    freq_ctl_d = freq_ctl_q;
    mbox_a_d   = mbox_a_q;
    mbox_b_d   = mbox_b_q;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PORT_SEL: begin
          // A select beyond the last port is dropped to keep reads defined.
          if (reg_wdata < 8'(NUM_PORTS)) begin
            sel_d = reg_wdata[PSEL_W-1:0];
          end
        end
        ADDR_FREQ_CTL: freq_ctl_d[sel_q] = reg_wdata;
        ADDR_MBOX_A:   mbox_a_d[sel_q] = reg_wdata;
        ADDR_MBOX_B:   mbox_b_d[sel_q] = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_q      <= PSEL_W'(PORT_SEL_RST);
      freq_ctl_q <= {NUM_PORTS{FREQ_CTL_RST}};
      mbox_a_q   <= {NUM_PORTS{MBOX_A_RST}};
      mbox_b_q   <= {NUM_PORTS{MBOX_B_RST}};
    end else begin
      sel_q      <= sel_d;
      freq_ctl_q <= freq_ctl_d;
      mbox_a_q   <= mbox_a_d;
      mbox_b_q   <= mbox_b_d;
    end
  end

  // Sticky error flags: a new event in the read cycle survives the clear.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      flags_d[p] = rd_flags[p] ? '0 : flags_q[p];
      flags_d[p][FLAG_LEN]   = flags_d[p][FLAG_LEN]   | pkt_len_mismatch[p];
      flags_d[p][FLAG_CKSUM] = flags_d[p][FLAG_CKSUM] | pkt_cksum_bad[p];
      flags_d[p][FLAG_ECC2]  = flags_d[p][FLAG_ECC2]  | hdr_ecc_multi[p];
      flags_d[p][FLAG_ECC1]  = flags_d[p][FLAG_ECC1]  | hdr_ecc_single[p];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Header path: one register stage, single-bit errors repaired.
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      hdr_v_d[p] = hdr_valid[p];
      hdr_d[p]   = hdr_in[p];
      if (hdr_ecc_single[p] && !hdr_ecc_multi[p]) begin
        hdr_d[p] = hdr_in[p] ^ (HDR_W'(1) << hdr_err_pos[p]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hdr_q   <= '0;
      hdr_v_q <= '0;
    end else begin
      hdr_q   <= hdr_d;
      hdr_v_q <= hdr_v_d;
    end
  end

  assign hdr_out       = hdr_q;
  assign hdr_out_valid = hdr_v_q;

  // Read data: registered, standing until the next read.
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PORT_SEL: rdata_d = 8'(sel_q);
        ADDR_LEN_HI:   rdata_d = len_rep[sel_q][15:8];
        ADDR_LEN_LO:   rdata_d = len_lo[sel_q];
        ADDR_FREQ_CTL: rdata_d = freq_ctl_q[sel_q];
        ADDR_MBOX_A:   rdata_d = mbox_a_q[sel_q];
        ADDR_MBOX_B:   rdata_d = mbox_b_q[sel_q];
        ADDR_FLAGS:    rdata_d = {4'h0, flags_q[sel_q]};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    rpvm_line_len u_len (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .line_end   (line_end[p]),
      .line_len   (line_len[p]),
      .frame_end  (frame_end[p]),
      .freeze_en  (line_length_change_irq_enable[p]),
      .rd_hi      (rd_hi[p]),
      .rd_lo      (rd_lo[p]),
      .len_report (len_rep[p]),
      .lo_read    (len_lo[p])
    );

    rpvm_freq_det #(
      .CYC2 (STABLE_CYC2),
      .CYC3 (STABLE_CYC3)
    ) u_freq (
      .sys_clk     (sys_clk),
      .sys_rst     (sys_rst),
      .meas_valid  (freq_valid[p]),
      .freq_meas   (freq_meas[p]),
      .hyst        (freq_ctl_q[p][HYST_LSB+1:HYST_LSB]),
      .stable_sel  (freq_ctl_q[p][STABLE_LSB+1:STABLE_LSB]),
      .low_limit   (freq_ctl_q[p][LOW_LSB+3:LOW_LSB]),
      .freq_held   (freq_held[p]),
      .freq_stable (freq_stable[p]),
      .clk_missing (link_clock_missing[p])
    );

    // Flags may only rise by an event and fall by a read of their port.
    a_len_flag_set: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      pkt_len_mismatch[p] |=> flags_q[p][FLAG_LEN])
      else $error("length mismatch flag not set");

    a_len_read_clear: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rd_flags[p] && !pkt_len_mismatch[p] |=> !flags_q[p][FLAG_LEN])
      else $error("length flag not cleared by read");

    a_flags_sticky: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !rd_flags[p] |=> (flags_q[p] & $past(flags_q[p])) == $past(flags_q[p]))
      else $error("error flag dropped without a read");

    a_cksum_flag_set: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      pkt_cksum_bad[p] |=> flags_q[p][FLAG_CKSUM])
      else $error("checksum flag not set");

    a_cksum_read_clear: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rd_flags[p] && !pkt_cksum_bad[p] |=> !flags_q[p][FLAG_CKSUM])
      else $error("checksum flag not cleared by read");

    a_multi_untouched: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      hdr_ecc_multi[p] |=> hdr_out[p] == $past(hdr_in[p])
        && flags_q[p][FLAG_ECC2])
      else $error("multi-bit header altered or unflagged");

    a_multi_read_clear: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rd_flags[p] && !hdr_ecc_multi[p] |=> !flags_q[p][FLAG_ECC2])
      else $error("multi-bit flag not cleared by read");

    a_single_repair: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      hdr_ecc_single[p] && !hdr_ecc_multi[p] && hdr_err_pos[p] < POS_W'(HDR_W)
      |=> hdr_out[p] != $past(hdr_in[p]) && flags_q[p][FLAG_ECC1])
      else $error("single-bit header not repaired");

    a_single_read_clear: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rd_flags[p] && !hdr_ecc_single[p] |=> !flags_q[p][FLAG_ECC1])
      else $error("single-bit flag not cleared by read");
  end

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_FLAGS |=> reg_rvalid && reg_rdata[7:4] == 4'h0)
    else $error("reserved flag bits not zero");

  a_scratch_reset: assert property (
    @(posedge sys_clk)
    sys_rst |=> mbox_a_q[0] == MBOX_A_RST && mbox_b_q[0] == MBOX_B_RST)
    else $error("scratch bytes not at reset value");

  a_scratch_hold: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !reg_wr |=> mbox_b_q == $past(mbox_b_q))
    else $error("scratch byte changed without a write");

  a_port_route: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == ADDR_MBOX_A
    |=> mbox_a_q[$past(sel_q)] == $past(reg_wdata))
    else $error("write not routed to selected port");

  a_read_route: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == ADDR_MBOX_B |=> reg_rdata == $past(mbox_b_q[sel_q]))
    else $error("read not routed to selected port");

endmodule // rpvm_top

// *** sim/rpvm_remote_model.sv ***
`timescale 1ns/1ps
module rpvm_remote_model #(
  parameter int N = 4
) (
  // Clock
  input  wire logic                               sys_clk,
  // Video timing
  output logic [N-1:0]                            line_end,
  output logic [N-1:0][rpvm_pkg::LEN_W-1:0]       line_len,
  output logic [N-1:0]                            frame_end,
  // Link clock measurement
  output logic [N-1:0]                            freq_valid,
  output logic [N-1:0][rpvm_pkg::FREQ_W-1:0]      freq_meas,
  // Packet errors and headers
  output logic [N-1:0]                            pkt_len_mismatch,
  output logic [N-1:0]                            pkt_cksum_bad,
  output logic [N-1:0]                            hdr_ecc_multi,
  output logic [N-1:0]                            hdr_ecc_single,
  output logic [N-1:0]                            hdr_valid,
  output logic [N-1:0][rpvm_pkg::HDR_W-1:0]       hdr_in,
  output logic [N-1:0][rpvm_pkg::POS_W-1:0]       hdr_err_pos
);
  import rpvm_pkg::*;

  // Data lines carry the inverse of their last value once released, so a
  // design that samples them outside the strobe sees garbage, not a copy.
  initial begin
    {line_end, frame_end, freq_valid, hdr_valid} = '0;
    {pkt_len_mismatch, pkt_cksum_bad} = '0;
    {hdr_ecc_multi, hdr_ecc_single} = '0;
    {line_len, freq_meas, hdr_in, hdr_err_pos} = '1;
  end

  // With same set, the frame ends on the edge that carries its last line.
  task automatic frame(int p, logic [15:0] a, logic [15:0] b,
                       logic same = 1'b0);
    @(posedge sys_clk);
    line_end[p] <= 1'h1;
    line_len[p] <= a;
    @(posedge sys_clk);
    line_len[p]  <= b;
    frame_end[p] <= same;
    @(posedge sys_clk);
    line_end[p]  <= 1'h0;
    line_len[p]  <= ~b;
    frame_end[p] <= ~same;
    @(posedge sys_clk);
    frame_end[p] <= 1'h0;
  endtask

  task automatic freq(int p, logic [7:0] v);
    @(posedge sys_clk);
    freq_valid[p] <= 1'h1;
    freq_meas[p]  <= v;
    @(posedge sys_clk);
    freq_valid[p] <= 1'h0;
    freq_meas[p]  <= ~v;
  endtask

  task automatic errs(int p, logic [3:0] m);
    @(posedge sys_clk);
    {pkt_len_mismatch[p], pkt_cksum_bad[p]} <= m[3:2];
    {hdr_ecc_multi[p], hdr_ecc_single[p]}   <= m[1:0];
    @(posedge sys_clk);
    {pkt_len_mismatch[p], pkt_cksum_bad[p]} <= 2'h0;
    {hdr_ecc_multi[p], hdr_ecc_single[p]}   <= 2'h0;
  endtask

  task automatic hdr(int p, logic [23:0] h, logic [4:0] pos, logic s,
                     logic m);
    @(posedge sys_clk);
    hdr_valid[p]      <= 1'h1;
    hdr_in[p]         <= h;
    hdr_err_pos[p]    <= pos;
    hdr_ecc_single[p] <= s;
    hdr_ecc_multi[p]  <= m;
    @(posedge sys_clk);
    hdr_valid[p]      <= 1'h0;
    hdr_in[p]         <= ~h;
    hdr_err_pos[p]    <= ~pos;
    hdr_ecc_single[p] <= 1'h0;
    hdr_ecc_multi[p]  <= 1'h0;
  endtask
endmodule // rpvm_remote_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import rpvm_pkg::*;
  localparam int N = NUM_PORTS;
  localparam int C2 = 20;
  localparam int C3 = 40;
  logic                     sys_clk = 1'h0;
  logic                     sys_rst = 1'h1;
  logic [7:0]               reg_addr = 8'h00;
  logic                     reg_wr = 1'h0;
  logic                     reg_rd = 1'h0;
  logic [7:0]               reg_wdata = 8'h00;
  logic [7:0]               reg_rdata;
  logic                     reg_rvalid;
  logic [N-1:0]             line_length_change_irq_enable = '0;
  logic [N-1:0]             line_end, frame_end, freq_valid;
  logic [N-1:0][LEN_W-1:0]  line_len;
  logic [N-1:0][FREQ_W-1:0] freq_meas, freq_held;
  logic [N-1:0]             freq_stable, link_clock_missing;
  logic [N-1:0]             pkt_len_mismatch, pkt_cksum_bad;
  logic [N-1:0]             hdr_ecc_multi, hdr_ecc_single;
  logic [N-1:0]             hdr_valid, hdr_out_valid;
  logic [N-1:0][HDR_W-1:0]  hdr_in, hdr_out;
  logic [N-1:0][POS_W-1:0]  hdr_err_pos;
  int                       bad_count = 0;
  int                       compares = 0;
  int                       cycles = 0;
  int                       seed = 96;
  logic [7:0]               exp_q[$];
  logic [7:0]               mbox[N][2];
  int cyc_tab[4] = '{STABLE_CYC0, STABLE_CYC1, C2, C3};

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  rpvm_top #(.NUM_PORTS(N), .STABLE_CYC2(C2), .STABLE_CYC3(C3)) i_dut (
    .sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .line_end, .line_len, .frame_end,
    .line_length_change_irq_enable, .freq_valid, .freq_meas, .freq_held,
    .freq_stable, .link_clock_missing, .pkt_len_mismatch, .pkt_cksum_bad,
    .hdr_ecc_multi, .hdr_ecc_single, .hdr_valid, .hdr_in, .hdr_err_pos,
    .hdr_out_valid, .hdr_out);

  rpvm_remote_model #(.N(N)) i_remote (
    .sys_clk, .line_end, .line_len, .frame_end, .freq_valid, .freq_meas,
    .pkt_len_mismatch, .pkt_cksum_bad, .hdr_ecc_multi, .hdr_ecc_single,
    .hdr_valid, .hdr_in, .hdr_err_pos);

  task automatic tally_and_finish();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("wrong value at %0t: read answers missing", $time);
    end
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check_rd(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(logic [23:0] got, logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: pin %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  // The expectation is queued before the strobe, so reads stay in order.
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
  endtask

  // Read data stands from the edge before, so sampling here is race free.
  always @(posedge sys_clk) begin
    cycles++;
    if (reg_rvalid === 1'h1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("wrong value at %0t: read answer not requested", $time);
      end else begin
        check_rd(reg_rdata, exp_q.pop_front());
      end
    end
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rd(ADDR_LEN_HI, 8'h00);
    rd(ADDR_LEN_LO, 8'h00);
    rd(ADDR_FREQ_CTL, 8'hC5);
    rd(ADDR_FLAGS, 8'h00);
    rd(8'h10, 8'h00);
    check_pin(24'(link_clock_missing[0]), 24'h1);
    for (int p = 0; p < N; p++) begin
      wr(ADDR_PORT_SEL, 8'(p));
      rd(ADDR_MBOX_A, 8'h00);
      rd(ADDR_MBOX_B, 8'h01);
      mbox[p][0] = 8'($random(seed));
      mbox[p][1] = 8'($random(seed));
      wr(ADDR_MBOX_A, mbox[p][0]);
      wr(ADDR_MBOX_B, mbox[p][1]);
    end
    wr(ADDR_PORT_SEL, 8'h07);
    rd(ADDR_PORT_SEL, 8'(N - 1));
    for (int p = 0; p < N; p++) begin
      wr(ADDR_PORT_SEL, 8'(p));
      rd(ADDR_MBOX_A, mbox[p][0]);
      rd(ADDR_MBOX_B, mbox[p][1]);
    end
    wr(ADDR_PORT_SEL, 8'h01);
    i_remote.frame(1, 16'h1234, 16'h0ABC);
    rd(ADDR_LEN_HI, 8'h0A);
    rd(ADDR_LEN_LO, 8'hBC);
    i_remote.frame(1, 16'h0000, 16'h0AB0);
    rd(ADDR_LEN_HI, 8'h0A);
    i_remote.frame(1, 16'h0000, 16'h1CD1, 1'h1);
    rd(ADDR_LEN_LO, 8'hB0);
    rd(ADDR_LEN_HI, 8'h1C);
    rd(ADDR_LEN_LO, 8'hD1);
    line_length_change_irq_enable[1] <= 1'h1;
    i_remote.frame(1, 16'h5555, 16'h0123);
    i_remote.frame(1, 16'h5555, 16'h0456);
    rd(ADDR_LEN_HI, 8'h01);
    rd(ADDR_LEN_LO, 8'h23);
    i_remote.frame(1, 16'h5555, 16'h0789);
    rd(ADDR_LEN_HI, 8'h07);
    rd(ADDR_LEN_LO, 8'h89);
    line_length_change_irq_enable[1] <= 1'h0;
    wr(ADDR_PORT_SEL, 8'h00);
    rd(ADDR_LEN_HI, 8'h00);
    wr(ADDR_PORT_SEL, 8'h02);
    i_remote.freq(2, 8'h32);
    @(negedge sys_clk);
    check_pin(24'(freq_held[2]), 24'h32);
    check_pin(24'(link_clock_missing[2]), 24'h0);
    i_remote.freq(2, 8'h35);
    @(negedge sys_clk);
    check_pin(24'(freq_held[2]), 24'h32);
    i_remote.freq(2, 8'h36);
    @(negedge sys_clk);
    check_pin(24'(freq_held[2]), 24'h36);
    i_remote.freq(2, 8'h05);
    @(negedge sys_clk);
    check_pin(24'(link_clock_missing[2]), 24'h0);
    i_remote.freq(2, 8'h01);
    @(negedge sys_clk);
    check_pin(24'(link_clock_missing[2]), 24'h1);
    wr(ADDR_FREQ_CTL, 8'h05);
    rd(ADDR_FREQ_CTL, 8'h05);
    i_remote.freq(2, 8'h02);
    @(negedge sys_clk);
    check_pin(24'(freq_held[2]), 24'h02);
    // Each capture restarts the stable count, so every code is timed afresh.
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_FREQ_CTL, 8'hC5 | 8'(c << 4));
      i_remote.freq(2, (c % 2 == 1) ? 8'h28 : 8'h46);
      repeat (cyc_tab[c] - 3) @(posedge sys_clk);
      @(negedge sys_clk);
      check_pin(24'(freq_stable[2]), 24'h0);
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      check_pin(24'(freq_stable[2]), 24'h1);
    end
    wr(ADDR_PORT_SEL, 8'h03);
    for (int b = 0; b < 4; b++) begin
      i_remote.errs(3, 4'(1 << b));
      rd(ADDR_FLAGS, 8'(1 << b));
      rd(ADDR_FLAGS, 8'h00);
    end
    i_remote.errs(3, 4'hF);
    rd(ADDR_FLAGS, 8'h0F);
    i_remote.hdr(0, 24'hA5C3F0, 5'h05, 1'h1, 1'h0);
    @(negedge sys_clk);
    check_pin(hdr_out[0], 24'hA5C3D0);
    check_pin(24'(hdr_out_valid[0]), 24'h1);
    i_remote.hdr(0, 24'h000000, 5'h17, 1'h1, 1'h0);
    @(negedge sys_clk);
    check_pin(hdr_out[0], 24'h800000);
    i_remote.hdr(0, 24'h123456, 5'h05, 1'h0, 1'h1);
    @(negedge sys_clk);
    check_pin(hdr_out[0], 24'h123456);
    wr(ADDR_PORT_SEL, 8'h00);
    rd(ADDR_FLAGS, 8'h03);
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule // testbench
